// *** rtl/orl_top.sv ***
// Overview of operation
// (R01) seven triggers OR into collective state
// (R02) per-trigger inversion before the OR
// (R03) unassigned slot always contributes zero
// (R04) channel inversion complements collective result
// (R05) no slots assigned forces state zero
// (R06) operating mode picks working or closed circuit
// (R07) unlatched contact follows collective state
// (R08) latched state held until valid ack
// (R09) ack needs triggers off and delay expired
// (R10) per-channel ack input resets its latch
// (R11) unlatch config or no slots releases
// (R12) minimum hold time after each change
// (R13) latched states restored after restart
// (R14) clear key acts as acknowledgment
// (R15) group ack signal acks all relays
// (R16) supervisory command acks all relays
// (R17) group and supervisory need remote reset
// (R18) life contact off at boot, on when healthy
// (R19) everything synchronous on one clock
// (R20) acks ORed, early ack ignored
`timescale 1ns/1ns
`default_nettype none
module orl_top #(
   parameter int unsigned BOOT_CYCLES = orl_pkg::BOOT_CYC
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [orl_pkg::NUM_CH*orl_pkg::NUM_TRIG-1:0] trig_i,
   input wire logic [orl_pkg::NUM_CH*orl_pkg::NUM_TRIG-1:0] assigned_i,
   input wire logic [orl_pkg::NUM_CH*orl_pkg::NUM_TRIG-1:0] trig_inv_i,
   input wire logic [orl_pkg::NUM_CH-1:0] coll_inv_i,
   input wire logic [orl_pkg::NUM_CH-1:0] closed_circuit_i,
   input wire logic [orl_pkg::NUM_CH-1:0] latched_i,
   input wire logic [orl_pkg::NUM_CH-1:0] ack_ch_i,
   input wire logic [orl_pkg::NUM_CH*orl_pkg::TMR_W-1:0] t_hold_i,
   input wire logic [orl_pkg::NUM_CH*orl_pkg::TMR_W-1:0] t_off_i,
   input wire logic clear_key_i,
   input wire logic ack_all_outputs_signal_i,
   input wire logic scada_ack_all_i,
   input wire logic remote_reset_en_i,
   input wire logic restore_i,
   input wire logic [orl_pkg::NUM_CH-1:0] restore_state_i,
   input wire logic internal_fault_i,
   output logic [orl_pkg::NUM_CH-1:0] contact_o,
   output logic [orl_pkg::NUM_CH-1:0] state_o,
   output logic [orl_pkg::NUM_CH-1:0] latch_o,
   output logic life_contact_relay_o,
   output logic life_led_o
);
   // panel key, group ack signal and fault inputs pass a two-stage synchroniser
   logic [1:0] key_s1_ff;
   logic [1:0] key_s2_ff;
   logic [1:0] flt_ff;
   logic group_ack;
   logic [orl_pkg::NUM_CH-1:0] ack_ch;
   orl_pkg::orl_life_t life_ff;
   orl_pkg::orl_life_t nxt_life;
   logic [31:0] boot_ff;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         key_s1_ff <= 2'h0;
         key_s2_ff <= 2'h0;
      end else if (ce_i) begin
         key_s1_ff <= {clear_key_i, ack_all_outputs_signal_i};
         key_s2_ff <= key_s1_ff;
      end
   end

   // only flt_ff[1] is read, the first stage may be metastable
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         flt_ff <= 2'h0;
      end else if (ce_i) begin
         flt_ff <= {flt_ff[0], internal_fault_i};
      end
   end

   // remote paths are gated, the panel key is not
   assign group_ack = key_s2_ff[1] // (R14)
      | (remote_reset_en_i & (key_s2_ff[0] | scada_ack_all_i)); // (R15) (R16) (R17)

   genvar c;
   generate
      for (c = 0; c < orl_pkg::NUM_CH; c++) begin : g_ch
         assign ack_ch[c] = ack_ch_i[c] | group_ack; // (R10) (R20)
         orl_channel u_ch (
            .mclk_i(mclk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .trig_i(trig_i[c*orl_pkg::NUM_TRIG +: orl_pkg::NUM_TRIG]),
            .assigned_i(assigned_i[c*orl_pkg::NUM_TRIG +: orl_pkg::NUM_TRIG]),
            .trig_inv_i(trig_inv_i[c*orl_pkg::NUM_TRIG +: orl_pkg::NUM_TRIG]),
            .coll_inv_i(coll_inv_i[c]),
            .closed_circuit_i(closed_circuit_i[c]),
            .latched_i(latched_i[c]),
            .ack_i(ack_ch[c]),
            .t_hold_i(t_hold_i[c*orl_pkg::TMR_W +: orl_pkg::TMR_W]),
            .t_off_i(t_off_i[c*orl_pkg::TMR_W +: orl_pkg::TMR_W]),
            .restore_i(restore_i),
            .restore_state_i(restore_state_i[c]),
            .state_o(state_o[c]),
            .latch_o(latch_o[c]),
            .contact_o(contact_o[c])
         );
      end
   endgenerate

   always_comb begin
      nxt_life = life_ff;
      unique case (life_ff)
         orl_pkg::ORL_LIFE_BOOT: begin
            if (boot_ff >= BOOT_CYCLES && !flt_ff[1]) begin
               nxt_life = orl_pkg::ORL_LIFE_OK;
            end
         end
         orl_pkg::ORL_LIFE_OK: begin
            if (flt_ff[1]) begin
               nxt_life = orl_pkg::ORL_LIFE_FAULT;
            end
         end
         orl_pkg::ORL_LIFE_FAULT: begin
            if (!flt_ff[1]) begin
               nxt_life = orl_pkg::ORL_LIFE_OK;
            end
         end
         default: begin
            nxt_life = orl_pkg::ORL_LIFE_BOOT;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         life_ff <= orl_pkg::ORL_LIFE_BOOT;
      end else if (ce_i) begin
         life_ff <= nxt_life; // (R18)
      end
   end

   // saturates so a long run cannot wrap back into the boot window
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         boot_ff <= 32'h0;
      end else if (ce_i) begin
         if (boot_ff < BOOT_CYCLES) begin
            boot_ff <= boot_ff + 32'h1;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         life_contact_relay_o <= 1'h0;
         life_led_o <= 1'h0;
      end else if (ce_i) begin
         life_contact_relay_o <= (nxt_life == orl_pkg::ORL_LIFE_OK); // (R18)
         life_led_o <= (nxt_life == orl_pkg::ORL_LIFE_OK);
      end
   end
endmodule
`default_nettype wire

// *** inc/orl_pkg.sv ***
package orl_pkg;
   localparam int unsigned NUM_TRIG = 7;
   localparam int unsigned NUM_CH = 4;
   localparam int unsigned TMR_W = 24;
   // tick = one mclk_i cycle at 50 MHz
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned BOOT_US = 100;
   localparam int unsigned BOOT_CYC = (BOOT_US * (CLK_HZ / 1_000_000));
   localparam logic [0:0] RST_CONTACT = 1'h0;
   localparam logic [0:0] RST_LATCH = 1'h0;
   typedef enum logic [1:0] {
      ORL_LIFE_BOOT = 2'b00,
      ORL_LIFE_OK = 2'b01,
      ORL_LIFE_FAULT = 2'b10
   } orl_life_t;
endpackage

// *** rtl/orl_channel.sv ***
`timescale 1ns/1ns
`default_nettype none
module orl_channel (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [orl_pkg::NUM_TRIG-1:0] trig_i,
   input wire logic [orl_pkg::NUM_TRIG-1:0] assigned_i,
   input wire logic [orl_pkg::NUM_TRIG-1:0] trig_inv_i,
   input wire logic coll_inv_i,
   input wire logic closed_circuit_i,
   input wire logic latched_i,
   input wire logic ack_i,
   input wire logic [orl_pkg::TMR_W-1:0] t_hold_i,
   input wire logic [orl_pkg::TMR_W-1:0] t_off_i,
   input wire logic restore_i,
   input wire logic restore_state_i,
   output logic state_o,
   output logic latch_o,
   output logic contact_o
);
   logic [orl_pkg::NUM_TRIG-1:0] eff;
   logic any_asg;
   logic coll;
   logic latch_ff;
   logic state_ff;
   logic contact_ff;
   logic [orl_pkg::TMR_W-1:0] hold_ff;
   logic [orl_pkg::TMR_W-1:0] off_ff;
   logic desired;
   logic released;

   genvar g;
   generate
      for (g = 0; g < orl_pkg::NUM_TRIG; g++) begin : g_trig
         // unassigned slot reads zero whatever its inversion
         assign eff[g] = assigned_i[g] & (trig_i[g] ^ trig_inv_i[g]); // (R02) (R03)
      end
   endgenerate

   assign any_asg = |assigned_i;
   assign coll = any_asg & ((|eff) ^ coll_inv_i); // (R01) (R04) (R05)
   // release retention: triggers quiet and t-off expired
   assign released = !coll && (off_ff == '0); // (R09)

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         off_ff <= '0;
      end else if (ce_i) begin
         if (coll) begin
            off_ff <= t_off_i;
         end else if (off_ff != '0) begin
            off_ff <= off_ff - orl_pkg::TMR_W'(1); // (R19)
         end
      end
   end

   // a stale ack is dropped, never queued
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         latch_ff <= orl_pkg::RST_LATCH;
      end else if (ce_i) begin
         if (restore_i) begin
            latch_ff <= restore_state_i; // (R13)
         end else if (!latched_i || !any_asg) begin
            if (released) begin
               latch_ff <= 1'b0; // (R11)
            end
         end else if (coll) begin
            latch_ff <= 1'b1; // (R08)
         end else if (ack_i && released) begin
            latch_ff <= 1'b0; // (R09) (R10) (R20)
         end
      end
   end

   // a latch still waiting for its release keeps the contact up after unlatching
   assign desired = coll | latch_ff; // (R07) (R08)

   // hold timer blocks any change until t-hold has elapsed
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state_ff <= orl_pkg::RST_CONTACT;
         hold_ff <= '0;
      end else if (ce_i) begin
         if (hold_ff != '0) begin
            hold_ff <= hold_ff - orl_pkg::TMR_W'(1); // (R12)
         end else if (desired != state_ff) begin
            state_ff <= desired;
            hold_ff <= t_hold_i; // (R12)
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         contact_ff <= orl_pkg::RST_CONTACT;
      end else if (ce_i) begin
         contact_ff <= state_ff ^ closed_circuit_i; // (R06)
      end
   end

   assign state_o = state_ff;
   assign latch_o = latch_ff;
   assign contact_o = contact_ff;
endmodule
`default_nettype wire

// *** testbench/orl_switchgear.sv ***
`timescale 1ns/1ns
`default_nettype none
module orl_switchgear (
   input wire logic mclk_i,
   input wire logic [3:0] contact_i,
   output logic [3:0] coil_o
);
   // the breaker coil lags the contact by a clock, so a glitch on the contact shows late
   always_ff @(posedge mclk_i) begin
      coil_o <= contact_i;
   end
endmodule
`default_nettype wire

// *** testbench/orl_top_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module orl_top_checker #(
   parameter int unsigned BOOT_CYCLES = 10
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [27:0] trig_i,
   input wire logic [27:0] assigned_i,
   input wire logic [27:0] trig_inv_i,
   input wire logic [3:0] coll_inv_i,
   input wire logic [3:0] closed_circuit_i,
   input wire logic [3:0] latched_i,
   input wire logic [95:0] t_hold_i,
   input wire logic restore_i,
   input wire logic internal_fault_i,
   input wire logic [3:0] contact_o,
   input wire logic [3:0] state_o,
   input wire logic [3:0] latch_o,
   input wire logic life_contact_relay_o,
   input wire logic life_led_o
);
   wire coll0 = (|assigned_i[6:0])
      & ((|((trig_i[6:0] ^ trig_inv_i[6:0]) & assigned_i[6:0])) ^ coll_inv_i[0]);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   life_led_a: assert property (life_led_o == life_contact_relay_o)
      else $error("life indicator differs from life contact");
   boot_dark_a: assert property ($fell(rst_i) |-> !life_contact_relay_o [*8])
      else $error("life contact up during boot");
   life_drop_a: assert property (internal_fault_i [*4] |=> !life_contact_relay_o)
      else $error("life contact up during fault");
   contact_mode_a: assert property (
      !$past(rst_i) && $past(ce_i)
         |-> contact_o == ($past(state_o) ^ $past(closed_circuit_i)))
      else $error("contact not state with mode applied");
   hold_time_a: assert property (
      $changed(state_o[0]) && t_hold_i[23:0] > 24'h2 |=> $stable(state_o[0]) [*3])
      else $error("state changed inside hold time");
   latch_set_a: assert property (
      ce_i && !restore_i && latched_i[0] && coll0 |=> latch_o[0])
      else $error("latch not set by active state");
   latch_cause_a: assert property ($rose(latch_o[0]) |-> $past(coll0) || $past(restore_i))
      else $error("latch set without cause");
   latch_keep_a: assert property ($fell(latch_o[0]) |-> !$past(coll0) || $past(restore_i))
      else $error("latch cleared while state active");
   enable_freeze_a: assert property (
      !ce_i |=> $stable(state_o) && $stable(contact_o) && $stable(latch_o)
         && $stable(life_contact_relay_o))
      else $error("outputs moved with clock enable low");
endmodule
bind orl_top orl_top_checker #(.BOOT_CYCLES(BOOT_CYCLES)) i_chk (.mclk_i, .rst_i, .ce_i, .trig_i,
   .assigned_i, .trig_inv_i, .coll_inv_i, .closed_circuit_i, .latched_i, .t_hold_i, .restore_i,
   .internal_fault_i, .contact_o, .state_o, .latch_o, .life_contact_relay_o, .life_led_o);
`default_nettype wire

// *** testbench/output_relay_latch_logic_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module output_relay_latch_logic_bench;
   logic mclk_i, rst_i, ce_i, remote_reset_en_i, restore_i, internal_fault_i;
   logic life_contact_relay_o, life_led_o;
   logic [27:0] trig_i, assigned_i, trig_inv_i;
   logic [95:0] t_hold_i, t_off_i;
   logic [3:0] coll_inv_i, closed_circuit_i, latched_i, restore_state_i, ackv;
   logic [3:0] contact_o, state_o, latch_o, exp, coil;
   wire [3:0] ack_ch_i = {3'h0, ackv[3]};
   wire clear_key_i = ackv[2];
   wire ack_all_outputs_signal_i = ackv[1];
   wire scada_ack_all_i = ackv[0];
   int bad_count, checks_done, seed, i, k, n;
   orl_top #(.BOOT_CYCLES(10)) i_dut (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .trig_i(trig_i),
      .assigned_i(assigned_i),
      .trig_inv_i(trig_inv_i),
      .coll_inv_i(coll_inv_i),
      .closed_circuit_i(closed_circuit_i),
      .latched_i(latched_i),
      .ack_ch_i(ack_ch_i),
      .t_hold_i(t_hold_i),
      .t_off_i(t_off_i),
      .clear_key_i(clear_key_i),
      .ack_all_outputs_signal_i(ack_all_outputs_signal_i),
      .scada_ack_all_i(scada_ack_all_i),
      .remote_reset_en_i(remote_reset_en_i),
      .restore_i(restore_i),
      .restore_state_i(restore_state_i),
      .internal_fault_i(internal_fault_i),
      .contact_o(contact_o),
      .state_o(state_o),
      .latch_o(latch_o),
      .life_contact_relay_o(life_contact_relay_o),
      .life_led_o(life_led_o)
   );
   orl_switchgear i_sw (.mclk_i(mclk_i), .contact_i(contact_o), .coil_o(coil));
   initial begin
      mclk_i = 0;
      forever #10 mclk_i = ~mclk_i;
   end
   task automatic tick(input int c);
      repeat (c) @(posedge mclk_i);
      #2;
   endtask
   task automatic cmp(input logic [3:0] got, input logic [3:0] want);
      checks_done++;
      if (got !== want) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, want);
      end
   endtask
   function automatic logic coll(input int c);
      logic [6:0] a;
      a = assigned_i[c*7+:7];
      return (|a) & ((|((trig_i[c*7+:7] ^ trig_inv_i[c*7+:7]) & a)) ^ coll_inv_i[c]);
   endfunction
   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      seed = 32'h5613;
      {trig_i, assigned_i, trig_inv_i, t_hold_i, t_off_i, coll_inv_i} = '0;
      {closed_circuit_i, latched_i, restore_state_i, ackv, restore_i, internal_fault_i} = '0;
      rst_i = 1;
      ce_i = 1;
      remote_reset_en_i = 1;
      tick(3);
      rst_i = 0;
      n = 0;
      while (life_contact_relay_o !== 1'h1 && n < 40) begin
         tick(1);
         n++;
      end
      cmp({2'h0, life_led_o, life_contact_relay_o}, 4'h3);
      internal_fault_i = 1;
      tick(6);
      cmp({2'h0, life_led_o, life_contact_relay_o}, 4'h0);
      internal_fault_i = 0;
      for (i = 0; i < 40; i++) begin
         trig_i = 28'($random(seed));
         // every fourth pass leaves all slots empty so forced-zero is hit often
         assigned_i = (i % 4 == 0) ? 28'h0 : 28'($random(seed));
         trig_inv_i = 28'($random(seed));
         {coll_inv_i, closed_circuit_i} = 8'($random(seed));
         tick(4);
         for (k = 0; k < 4; k++) exp[k] = coll(k);
         cmp(state_o, exp);
         cmp(contact_o, exp ^ closed_circuit_i);
         cmp(coil, exp ^ closed_circuit_i);
      end
      // with the enable low nothing may move, whatever the triggers do
      ce_i = 0;
      trig_i = ~trig_i;
      tick(4);
      cmp(state_o, exp);
      cmp(contact_o, exp ^ closed_circuit_i);
      ce_i = 1;
      {assigned_i, trig_inv_i, coll_inv_i, closed_circuit_i} = '0;
      assigned_i[0] = 1;
      latched_i = 4'h1;
      t_hold_i[23:0] = 24'h5;
      t_off_i[23:0] = 24'h8;
      // sources: channel ack, panel key, group ack, supervisory, supervisory without permission
      for (k = 0; k < 5; k++) begin
         remote_reset_en_i = (k != 4);
         trig_i[0] = 1;
         tick(2);
         ackv = 4'hf;
         tick(1);
         ackv = 4'h0;
         tick(4);
         trig_i[0] = 0;
         tick(20);
         cmp(latch_o, 4'h1);
         ackv = (k == 4) ? 4'h1 : 4'h8 >> k;
         tick(1);
         ackv = 4'h0;
         tick(4);
         cmp(latch_o, {3'h0, k == 4});
      end
      latched_i = 4'h0;
      tick(20);
      cmp(latch_o, 4'h0);
      latched_i = 4'h1;
      restore_state_i = 4'h1;
      restore_i = 1;
      tick(1);
      restore_i = 0;
      tick(2);
      cmp(latch_o, 4'h1);
      // emptying every slot releases the latch once triggers are quiet
      assigned_i[0] = 0;
      tick(3);
      cmp(latch_o, 4'h0);
      final_report();
   end
endmodule
`default_nettype wire
